//--- verilog/sigio_pkg.sv
// Constants, codes and register map of the signalling I/O function mapper
package sigio_pkg;
  // Number of input and output channels
  localparam int NUM_CH = 2;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IN_CFG_OFS = 8'h04;
  localparam logic [7:0] OUT_CFG_OFS = 8'h08;
  localparam logic [7:0] PRE_DELAY_OFS = 8'h0C;
  localparam logic [7:0] POST_DELAY_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // Field layout: per channel 8-bit slice, function low nibble, polarity bit 4
  localparam int CH_STRIDE = 8;
  localparam int POL_BIT = 4;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  // Delay tick: 1 ms at 250 MHz
  localparam int TICK_TIME_US = 1000;
  localparam int CLK_MHZ = 250;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
  // Input function codes
  typedef enum logic [3:0] {
    IN_NONE = 4'h0, IN_ESTOP = 4'h1, IN_TEST_ON = 4'h2, IN_TEST_OFF = 4'h3,
    IN_INH_AUTO = 4'h4, IN_MAN_RETR = 4'h5, IN_PRIO_ONE = 4'h6, IN_PRIO_TWO = 4'h7,
    IN_INH_XFER = 4'h8, IN_BYPASS = 4'h9, IN_RC_ONE = 4'hA, IN_RC_OFF = 4'hB,
    IN_RC_TWO = 4'hC, IN_ALM_RST = 4'hD, IN_MODE_TGL = 4'hE
  } in_func_t;
  // Output function codes
  typedef enum logic [3:0] {
    OUT_NONE = 4'h0, OUT_ALARM = 4'h1, OUT_POS_ONE = 4'h2, OUT_POS_OFF = 4'h3,
    OUT_POS_TWO = 4'h4, OUT_PRE_XFER = 4'h5
  } out_func_t;
  // Switch position codes from the controller
  localparam logic [1:0] POS_OFF = 2'h0;
  localparam logic [1:0] POS_ONE = 2'h1;
  localparam logic [1:0] POS_TWO = 2'h2;
  // Pre-transfer sequencer states
  typedef enum logic [1:0] {
    XS_IDLE = 2'b00, XS_PRE = 2'b01, XS_GO = 2'b10, XS_POST = 2'b11
  } xfer_state_t;
endpackage

//--- verilog/signalling_io_function_mapper.sv
// Two-input, two-contact function mapper with APB configuration
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module signalling_io_function_mapper #(
  parameter int TICK_CYCLES = sigio_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] input_pin,
  input wire logic module_present,
  input wire logic [1:0] switch_pos,
  input wire logic delayed_type,
  input wire logic t2t_app,
  input wire logic alarm_active,
  input wire logic auto_disabled,
  input wire logic transfer_request,
  input wire logic transfer_done,
  output logic [1:0] contact_out,
  output logic menu_enable,
  output logic goto_off,
  output logic goto_source_one,
  output logic goto_source_two,
  output logic auto_block,
  output logic inhibit_auto,
  output logic no_retransfer,
  output logic no_transfer,
  output logic priority_valid,
  output logic priority_two,
  output logic bypass_pulse,
  output logic test_on_pulse,
  output logic test_off_pulse,
  output logic alarm_reset_pulse,
  output logic auto_mode,
  output logic transfer_go
);

  // Software-visible configuration
  logic bus_enable; // Local bus enable bit
  logic [31:0] in_cfg; // Input function and polarity
  logic [31:0] out_cfg; // Output function and polarity
  logic [15:0] pre_delay; // Pre-transfer delay in ticks
  logic [15:0] post_delay; // Post-transfer delay in ticks

  // Synchronisers for pin inputs
  logic [1:0] pin_meta; // First stage, read only by second
  logic [1:0] pin_sync; // Safe level
  logic present_meta; // First stage of presence
  logic present_sync; // Safe presence level

  // Decoded input activity
  logic [1:0] in_act; // Logical active level
  logic [1:0] in_act_prev; // Previous logical level
  logic [1:0] in_edge; // Activation edge
  logic [15:0] func_lvl; // Any input active, per function
  logic [15:0] func_edge; // Any input activating, per function

  // Tick divider and sequencer
  logic [31:0] tick_cnt; // Cycle counter toward one tick
  logic tick; // One-cycle tick enable
  sigio_pkg::xfer_state_t xs; // Sequencer state
  logic [15:0] delay_cnt; // Remaining ticks
  logic pre_active; // Pre-transfer signal level

  // Bus decode helpers
  logic wr_en; // Write taken this cycle
  logic cfg_locked; // Config writes refused
  logic [1:0] out_val; // Output function value before polarity
  logic [31:0] next_prdata; // Read mux
  logic next_pslverr; // Unmapped address flag
  logic estop_off; // Emergency stop forcing off

  // Input pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      present_meta <= 1'b0;
      present_sync <= 1'b0;
    end else begin
      pin_meta <= input_pin;
      pin_sync <= pin_meta;
      present_meta <= module_present;
      present_sync <= present_meta;
    end
  end

  // Polarity: normally open is active when closed (pin high)
  always_comb begin
    for (int i = 0; i < sigio_pkg::NUM_CH; i++) begin
      in_act[i] = pin_sync[i] ^ in_cfg[i * sigio_pkg::CH_STRIDE + sigio_pkg::POL_BIT];
    end
  end

  // Previous level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_act_prev <= 2'h0;
    end else begin
      in_act_prev <= in_act;
    end
  end

  // Activation edge: rising for NO, falling pin for NC
  assign in_edge = in_act & ~in_act_prev;

  // Gather activity by assigned function; code zero matches nothing used
  always_comb begin
    func_lvl = 16'h0000;
    func_edge = 16'h0000;
    for (int i = 0; i < sigio_pkg::NUM_CH; i++) begin
      func_lvl[in_cfg[i * sigio_pkg::CH_STRIDE +: 4]] =
        func_lvl[in_cfg[i * sigio_pkg::CH_STRIDE +: 4]] | in_act[i];
      func_edge[in_cfg[i * sigio_pkg::CH_STRIDE +: 4]] =
        func_edge[in_cfg[i * sigio_pkg::CH_STRIDE +: 4]] | in_edge[i];
    end
  end

  // Emergency stop only drives to off on three-position switches
  assign estop_off = func_lvl[sigio_pkg::IN_ESTOP] & delayed_type;

  // Position commands with fixed priority: off, then one, then two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      goto_off <= 1'b0;
      goto_source_one <= 1'b0;
      goto_source_two <= 1'b0;
    end else begin
      // Emergency stop overrides the inhibit; safety first
      goto_off <= estop_off | (func_lvl[sigio_pkg::IN_RC_OFF]
        & ~func_lvl[sigio_pkg::IN_INH_AUTO]);
      goto_source_one <= func_lvl[sigio_pkg::IN_RC_ONE] & ~func_lvl[sigio_pkg::IN_RC_OFF]
        & ~estop_off & ~func_lvl[sigio_pkg::IN_INH_AUTO];
      goto_source_two <= func_lvl[sigio_pkg::IN_RC_TWO] & ~func_lvl[sigio_pkg::IN_RC_OFF]
        & ~func_lvl[sigio_pkg::IN_RC_ONE] & ~estop_off
        & ~func_lvl[sigio_pkg::IN_INH_AUTO];
    end
  end

  // Level-type blocking signals to the controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_block <= 1'b0;
      inhibit_auto <= 1'b0;
      no_retransfer <= 1'b0;
      no_transfer <= 1'b0;
    end else begin
      auto_block <= func_lvl[sigio_pkg::IN_ESTOP];
      inhibit_auto <= func_lvl[sigio_pkg::IN_INH_AUTO];
      no_retransfer <= func_lvl[sigio_pkg::IN_MAN_RETR];
      no_transfer <= func_lvl[sigio_pkg::IN_INH_XFER];
    end
  end

  // Priority selection, only meaningful in transformer-transformer use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_valid <= 1'b0;
      priority_two <= 1'b0;
    end else begin
      // Source one wins when both are asserted at once
      priority_valid <= t2t_app & (func_lvl[sigio_pkg::IN_PRIO_ONE]
        | func_lvl[sigio_pkg::IN_PRIO_TWO]);
      priority_two <= t2t_app & func_lvl[sigio_pkg::IN_PRIO_TWO]
        & ~func_lvl[sigio_pkg::IN_PRIO_ONE];
    end
  end

  // Edge-type pulses; a held contact gives one pulse only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_pulse <= 1'b0;
      test_on_pulse <= 1'b0;
      test_off_pulse <= 1'b0;
      alarm_reset_pulse <= 1'b0;
    end else begin
      bypass_pulse <= func_edge[sigio_pkg::IN_BYPASS];
      test_on_pulse <= func_edge[sigio_pkg::IN_TEST_ON]
        & ~func_lvl[sigio_pkg::IN_INH_AUTO];
      test_off_pulse <= func_edge[sigio_pkg::IN_TEST_OFF]
        & ~func_lvl[sigio_pkg::IN_INH_AUTO];
      alarm_reset_pulse <= func_edge[sigio_pkg::IN_ALM_RST];
    end
  end

  // Automatic/panel mode flips on the activation edge, never on level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_mode <= 1'b1;
    end else if (func_edge[sigio_pkg::IN_MODE_TGL] & ~func_lvl[sigio_pkg::IN_INH_AUTO]) begin
      auto_mode <= ~auto_mode;
    end
  end

  // Menus need power (reset released), bus enabled and presence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_enable <= 1'b0;
    end else begin
      menu_enable <= bus_enable & present_sync;
    end
  end

  // Millisecond tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // Pre-transfer sequencer; bypass cuts whichever delay is counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs <= sigio_pkg::XS_IDLE;
      delay_cnt <= 16'h0000;
      pre_active <= 1'b0;
      transfer_go <= 1'b0;
    end else begin
      case (xs)
        sigio_pkg::XS_IDLE: begin
          if (transfer_request) begin
            // Without a pre-transfer output the transfer goes at once
            if (out_val_pre_any()) begin
              pre_active <= 1'b1;
              delay_cnt <= pre_delay;
              xs <= sigio_pkg::XS_PRE;
            end else begin
              transfer_go <= 1'b1;
              xs <= sigio_pkg::XS_GO;
            end
          end
        end
        sigio_pkg::XS_PRE: begin
          // Transfer waits out the pre delay
          if (delay_cnt == 16'h0000 || func_edge[sigio_pkg::IN_BYPASS]) begin
            transfer_go <= 1'b1;
            xs <= sigio_pkg::XS_GO;
          end else if (tick) begin
            delay_cnt <= delay_cnt - 16'h0001;
          end
        end
        sigio_pkg::XS_GO: begin
          if (transfer_done) begin
            transfer_go <= 1'b0;
            delay_cnt <= post_delay;
            xs <= pre_active ? sigio_pkg::XS_POST : sigio_pkg::XS_IDLE;
          end
        end
        sigio_pkg::XS_POST: begin
          // Signal held after transfer for the post delay
          if (delay_cnt == 16'h0000 || func_edge[sigio_pkg::IN_BYPASS]) begin
            pre_active <= 1'b0;
            xs <= sigio_pkg::XS_IDLE;
          end else if (tick) begin
            delay_cnt <= delay_cnt - 16'h0001;
          end
        end
        default: begin
          xs <= sigio_pkg::XS_IDLE;
          pre_active <= 1'b0;
          transfer_go <= 1'b0;
        end
      endcase
    end
  end

  // True when some output carries the pre-transfer function
  function automatic logic out_val_pre_any();
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sigio_pkg::NUM_CH; i++) begin
      hit = hit | (out_cfg[i * sigio_pkg::CH_STRIDE +: 4] == 4'(sigio_pkg::OUT_PRE_XFER));
    end
    return hit;
  endfunction

  // Output function values; unknown codes stay inactive
  always_comb begin
    for (int i = 0; i < sigio_pkg::NUM_CH; i++) begin
      case (out_cfg[i * sigio_pkg::CH_STRIDE +: 4])
        4'(sigio_pkg::OUT_ALARM): out_val[i] = alarm_active | auto_disabled;
        4'(sigio_pkg::OUT_POS_ONE): out_val[i] = switch_pos == sigio_pkg::POS_ONE;
        4'(sigio_pkg::OUT_POS_OFF): out_val[i] = switch_pos == sigio_pkg::POS_OFF;
        4'(sigio_pkg::OUT_POS_TWO): out_val[i] = switch_pos == sigio_pkg::POS_TWO;
        4'(sigio_pkg::OUT_PRE_XFER): out_val[i] = pre_active;
        default: out_val[i] = 1'b0;
      endcase
    end
  end

  // Contacts: NO closes when active, NC opens when active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_out <= 2'h0;
    end else begin
      for (int i = 0; i < sigio_pkg::NUM_CH; i++) begin
        contact_out[i] <= out_val[i] ^ out_cfg[i * sigio_pkg::CH_STRIDE + sigio_pkg::POL_BIT];
      end
    end
  end

  // APB: one wait state, write lands at the completing edge
  assign wr_en = psel & penable & pwrite & pready;
  // Config frozen while automatic mode is inhibited
  assign cfg_locked = func_lvl[sigio_pkg::IN_INH_AUTO];

  // Ready pulses once per access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Register writes; refused writes to config still complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_enable <= sigio_pkg::CTRL_RST[0];
      in_cfg <= sigio_pkg::CFG_RST;
      out_cfg <= sigio_pkg::CFG_RST;
      pre_delay <= sigio_pkg::DELAY_RST;
      post_delay <= sigio_pkg::DELAY_RST;
    end else if (wr_en) begin
      case (paddr)
        sigio_pkg::CTRL_OFS: bus_enable <= pwdata[0];
        sigio_pkg::IN_CFG_OFS: if (!cfg_locked) in_cfg <= pwdata & 32'h0000_1F1F;
        sigio_pkg::OUT_CFG_OFS: if (!cfg_locked) out_cfg <= pwdata & 32'h0000_1F1F;
        sigio_pkg::PRE_DELAY_OFS: if (!cfg_locked) pre_delay <= pwdata[15:0];
        sigio_pkg::POST_DELAY_OFS: if (!cfg_locked) post_delay <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux and unmapped-address detection
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      sigio_pkg::CTRL_OFS: next_prdata = {31'h0, bus_enable};
      sigio_pkg::IN_CFG_OFS: next_prdata = in_cfg;
      sigio_pkg::OUT_CFG_OFS: next_prdata = out_cfg;
      sigio_pkg::PRE_DELAY_OFS: next_prdata = {16'h0000, pre_delay};
      sigio_pkg::POST_DELAY_OFS: next_prdata = {16'h0000, post_delay};
      sigio_pkg::STATUS_OFS: next_prdata = {21'h0, xs, menu_enable, pre_active,
        auto_mode, switch_pos, contact_out, in_act};
      default: next_pslverr = 1'b1;
    endcase
  end

  // Read data and error registered for the ready cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end else begin
      pslverr <= 1'b0;
    end
  end

endmodule

//--- tb/sigio_checker_assertions.sv
// Port-level checker of the signalling function mapper
`timescale 1ns/1ns
module sigio_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic module_present,
  input wire logic delayed_type,
  input wire logic transfer_request,
  input wire logic transfer_done,
  input wire logic menu_enable,
  input wire logic goto_off,
  input wire logic goto_source_one,
  input wire logic goto_source_two,
  input wire logic auto_block,
  input wire logic test_on_pulse,
  input wire logic bypass_pulse,
  input wire logic auto_mode,
  input wire logic transfer_go
);
  // One clock domain, so one default for all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_off_beats_one: assert property (!(goto_off && goto_source_one))
    else $error("off and source one commanded together");
  a_two_last: assert property (goto_source_two |-> !goto_off && !goto_source_one)
    else $error("source two commanded beside a stronger command");
  a_test_single: assert property (test_on_pulse |=> !test_on_pulse)
    else $error("test pulse longer than one cycle");
  a_bypass_single: assert property (bypass_pulse |=> !bypass_pulse)
    else $error("bypass pulse longer than one cycle");
  a_mode_edge: assert property ($changed(auto_mode) |=> $stable(auto_mode))
    else $error("mode toggled on consecutive cycles");
  a_go_on_request: assert property ($rose(transfer_go) |-> $past(transfer_request))
    else $error("transfer started without a request");
  a_done_drops_go: assert property (transfer_go && transfer_done |=> !transfer_go)
    else $error("transfer go held after completion");
  a_menu_present: assert property (!module_present [*4] |-> !menu_enable)
    else $error("menus offered without the module");
  a_estop_off: assert property (auto_block && delayed_type && $past(delayed_type) |-> goto_off)
    else $error("emergency stop did not command off");
endmodule
bind signalling_io_function_mapper sigio_checker u_chk (.*);

//--- tb/ctrl_model.sv
// Behavioural model of the transfer switch controller side
`timescale 1ns/1ns
module ctrl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want,
  input wire logic [1:0] target,
  input wire logic [3:0] lat,
  input wire logic transfer_go,
  output logic transfer_request,
  output logic transfer_done,
  output logic [1:0] switch_pos
);
  int cnt; // Cycles spent with go high
  // Request held until go; done after lat+1 cycles of go, so fast and slow answers both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_request <= 1'h0;
      transfer_done <= 1'h0;
      switch_pos <= sigio_pkg::POS_OFF;
      cnt <= 0;
    end else begin
      transfer_done <= 1'h0;
      transfer_request <= want && !transfer_go;
      if (transfer_go) begin
        cnt <= cnt + 1;
        // Single done pulse: count moves past lat afterwards
        if (cnt == int'(lat)) begin
          transfer_done <= 1'h1;
          switch_pos <= target;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench of the signalling function mapper
`timescale 1ns/1ns
module tb;
  localparam int TK = 4; // Short tick keeps delays to a handful of cycles
  localparam int PRE = 2;
  localparam int POST = 1;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, want = 1'h0;
  logic [1:0] input_pin = 2'h0, switch_pos, contact_out, target = 2'h0;
  logic [3:0] lat = 4'h0, pv;
  logic module_present = 1'h0, delayed_type = 1'h0, t2t_app = 1'h0, alarm_active = 1'h0;
  logic auto_disabled = 1'h0, transfer_request, transfer_done, menu_enable, goto_off;
  logic goto_source_one, goto_source_two, auto_block, inhibit_auto, no_retransfer;
  logic no_transfer, priority_valid, priority_two, bypass_pulse, test_on_pulse;
  logic test_off_pulse, alarm_reset_pulse, auto_mode, transfer_go;
  logic [8:0] lv;
  int mismatches = 0, checks_done = 0;
  always #2 pclk = ~pclk;
  assign pv = {alarm_reset_pulse, bypass_pulse, test_off_pulse, test_on_pulse};
  assign lv = {goto_off, goto_source_one, goto_source_two, auto_block, inhibit_auto,
    no_retransfer, no_transfer, priority_valid, priority_two};
  signalling_io_function_mapper #(.TICK_CYCLES(TK)) dut (.*);
  ctrl_model ctl (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bounded wait step; running out counts as a failure
  task automatic step(inout int n);
    @(posedge pclk);
    n++;
    if (n > 300) begin
      mismatches++;
      stop_test;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; an idle edge after it avoids back-to-back NBA clashes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do step(n); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  // Counts cycles with the expected pulse and with any pulse
  task automatic win(input logic [3:0] e, output logic [7:0] w);
    w = 8'h00;
    repeat (8) begin
      @(posedge pclk);
      w[3:0] += 4'(pv === e);
      w[7:4] += 4'(pv !== 4'h0);
    end
  endtask
  task automatic t_reset;
    apb(1'h0, sigio_pkg::IN_CFG_OFS, 32'h0);
    chk(rd, sigio_pkg::CFG_RST);
    apb(1'h0, sigio_pkg::OUT_CFG_OFS, 32'h0);
    chk(rd, sigio_pkg::CFG_RST);
    input_pin <= 2'h3;
    cyc(6);
    chk({auto_mode, pv, lv, contact_out}, 16'h8000);
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1);
    input_pin <= 2'h2;
  endtask
  task automatic t_menu;
    wr(sigio_pkg::CTRL_OFS, 32'h1);
    module_present <= 1'h1;
    cyc(5);
    chk(menu_enable, 1'h1);
    module_present <= 1'h0;
    cyc(5);
    chk(menu_enable, 1'h0);
    module_present <= 1'h1;
    wr(sigio_pkg::CTRL_OFS, 32'h0);
    cyc(5);
    chk(menu_enable, 1'h0);
  endtask
  // Channel 0 normally open, channel 1 normally closed, same function
  task automatic t_pulses;
    logic [3:0] code [4] = '{4'h2, 4'h3, 4'h9, 4'hD}; // Test on/off, bypass, alarm reset
    logic [7:0] w;
    for (int i = 0; i < 4; i++) begin
      wr(sigio_pkg::IN_CFG_OFS, {19'h0, 1'h1, code[i], 4'h0, code[i]});
      input_pin <= 2'h3;
      win(4'(1 << i), w);
      chk(w, 8'h11);
      input_pin <= 2'h2;
      win(4'(1 << i), w);
      chk(w, 8'h00);
      input_pin <= 2'h0;
      win(4'(1 << i), w);
      chk(w, 8'h11);
      input_pin <= 2'h2;
      win(4'(1 << i), w);
      chk(w, 8'h00);
    end
    input_pin <= 2'h0;
    wr(sigio_pkg::IN_CFG_OFS, 32'h0000_000E);
    input_pin <= 2'h1;
    cyc(12);
    chk(auto_mode, 1'h0);
    input_pin <= 2'h0;
    cyc(6);
    chk(auto_mode, 1'h0);
    input_pin <= 2'h1;
    cyc(6);
    chk(auto_mode, 1'h1);
    input_pin <= 2'h0;
  endtask
  // Rows: channel 0 code, channel 1 code, expected level outputs
  task automatic t_levels;
    logic [16:0] row [8] = '{{4'hA, 4'hC, 9'h080}, {4'hB, 4'hA, 9'h100},
      {4'hC, 4'h0, 9'h040}, {4'h1, 4'h0, 9'h120}, {4'h5, 4'h8, 9'h00C},
      {4'h7, 4'h0, 9'h003}, {4'h6, 4'h7, 9'h002}, {4'h4, 4'hA, 9'h010}};
    delayed_type <= 1'h1;
    t2t_app <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      wr(sigio_pkg::IN_CFG_OFS, {20'h0, row[i][12:9], 4'h0, row[i][16:13]});
      input_pin <= 2'h3;
      cyc(5);
      chk(lv, row[i][8:0]);
      input_pin <= 2'h0;
      cyc(5);
    end
    // Configuration frozen while the inhibit is held
    input_pin <= 2'h1;
    cyc(5);
    wr(sigio_pkg::IN_CFG_OFS, 32'h0);
    apb(1'h0, sigio_pkg::IN_CFG_OFS, 32'h0);
    chk(rd, 32'h0000_0A04);
    input_pin <= 2'h0;
    cyc(5);
    wr(sigio_pkg::IN_CFG_OFS, 32'h0);
    apb(1'h0, sigio_pkg::IN_CFG_OFS, 32'h0);
    chk(rd, 32'h0);
    // Open-transition switch, no transformer pairing: stop only blocks auto
    delayed_type <= 1'h0;
    t2t_app <= 1'h0;
    wr(sigio_pkg::IN_CFG_OFS, 32'h0000_0701);
    input_pin <= 2'h3;
    cyc(5);
    chk(lv, 9'h020);
    apb(1'h0, sigio_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0043);
    input_pin <= 2'h0;
    cyc(5);
    wr(sigio_pkg::IN_CFG_OFS, 32'h0);
  endtask
  task automatic xfer(input logic [1:0] t);
    int n;
    n = 0;
    target <= t;
    want <= 1'h1;
    while (transfer_go !== 1'h1) step(n);
    want <= 1'h0;
    chk(n > (PRE - 1) * TK, 1'h1);
    chk(contact_out[1], 1'h1);
    while (transfer_go !== 1'h0) step(n);
    chk(contact_out[1], 1'h1);
    n = 0;
    while (contact_out[1] !== 1'h0) step(n);
    chk(n <= (POST + 1) * TK + 4, 1'h1);
  endtask
  task automatic t_outputs;
    logic [3:0] pf [3] = '{4'h2, 4'h4, 4'h3}; // Position one, two, off
    logic [1:0] tg [3] = '{2'h1, 2'h2, 2'h0};
    wr(sigio_pkg::PRE_DELAY_OFS, 32'(PRE));
    wr(sigio_pkg::POST_DELAY_OFS, 32'(POST));
    wr(sigio_pkg::OUT_CFG_OFS, 32'h0000_0501);
    alarm_active <= 1'h1;
    cyc(3);
    chk(contact_out[0], 1'h1);
    alarm_active <= 1'h0;
    auto_disabled <= 1'h1;
    cyc(3);
    chk(contact_out[0], 1'h1);
    auto_disabled <= 1'h0;
    cyc(3);
    chk(contact_out[0], 1'h0);
    for (int i = 0; i < 3; i++) begin
      wr(sigio_pkg::OUT_CFG_OFS, {20'h5, 4'h0, pf[i]});
      lat <= 4'(i * 4);
      cyc(2);
      chk(contact_out[0], 1'h0);
      xfer(tg[i]);
      cyc(2);
      chk(contact_out[0], 1'h1);
    end
    wr(sigio_pkg::OUT_CFG_OFS, 32'h0000_0012);
    cyc(2);
    chk(contact_out[0], 1'h1);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset;
    t_menu;
    t_pulses;
    t_levels;
    t_outputs;
    stop_test;
  end
endmodule
